// >>> rtl/balu_pkg.sv
// package: operation codes, flag layout, bus map and carrier structs
package balu_pkg;

    // ==========================================================
    // widths
    localparam int BALU_REG_COUNT = 32;
    localparam int BALU_IDX_W = 5;
    localparam int BALU_ADDR_W = 6;

    // ==========================================================
    // status flag positions
    localparam int BALU_FLAG_C = 0;
    localparam int BALU_FLAG_Z = 1;
    localparam int BALU_FLAG_N = 2;
    localparam int BALU_FLAG_V = 3;
    localparam int BALU_FLAG_S = 4;
    localparam int BALU_FLAG_H = 5;
    localparam int BALU_FLAG_T = 6;
    localparam int BALU_FLAG_I = 7;

    // ==========================================================
    // register bus map and reset values
    localparam logic [5:0] BALU_ADDR_FLAGS = 6'h20;
    localparam logic [7:0] BALU_FLAGS_RST = 8'h00;
    localparam logic [7:0] BALU_GPR_RST = 8'h00;
    localparam logic [7:0] BALU_ALL_ONES = 8'hff;
    localparam logic [4:0] BALU_PROD_LOW_IDX = 5'h00;

    // ==========================================================
    // cycle costs
    localparam logic [1:0] BALU_CYC_SINGLE = 2'h1;
    localparam logic [1:0] BALU_CYC_DOUBLE = 2'h2;

    typedef enum logic [4:0] {
        OP_ADD_REGISTERS = 5'b00000,
        OP_ADD_WITH_CARRY = 5'b00001,
        OP_WORD_ADD_IMMEDIATE = 5'b00010,
        OP_SUBTRACT_REGISTERS = 5'b00011,
        OP_SUBTRACT_IMMEDIATE = 5'b00100,
        OP_SUBTRACT_WITH_CARRY = 5'b00101,
        OP_SUBTRACT_WITH_CARRY_IMMEDIATE = 5'b00110,
        OP_WORD_SUBTRACT_IMMEDIATE = 5'b00111,
        OP_AND_REGISTERS = 5'b01000,
        OP_AND_IMMEDIATE = 5'b01001,
        OP_OR_REGISTERS = 5'b01010,
        OP_OR_IMMEDIATE = 5'b01011,
        OP_XOR_REGISTERS = 5'b01100,
        OP_ONES_COMPLEMENT = 5'b01101,
        OP_BIT_SET = 5'b01110,
        OP_BIT_CLEAR = 5'b01111,
        OP_INCREMENT = 5'b10000,
        OP_DECREMENT = 5'b10001,
        OP_TEST = 5'b10010,
        OP_CLEAR = 5'b10011,
        OP_MULTIPLY_UNSIGNED = 5'b10100,
        OP_MULTIPLY_SIGNED = 5'b10101,
        OP_MULTIPLY_SIGNED_UNSIGNED = 5'b10110,
        OP_FRAC_MULTIPLY_UNSIGNED = 5'b10111,
        OP_FRAC_MULTIPLY_SIGNED = 5'b11000,
        OP_FRAC_MULTIPLY_SIGNED_UNSIGNED = 5'b11001
    } balu_op_type;

    typedef struct packed {
        logic valid;
        balu_op_type op;
        logic [4:0] dst;
        logic [4:0] src;
        logic [7:0] imm;
    } balu_req_type;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } balu_bus_type;

endpackage

// >>> rtl/balu_core.sv
// byte datapath: register file, arithmetic, logic, multiply and flags
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps

// Contract
// - add registers into destination, update Z C N V H, one clock.
// - add registers plus carry into destination, update Z C N V H, one clock.
// - add constant to 16-bit pair, update Z C N V S, two clocks.
// - subtract source from destination, update Z C N V H, one clock.
// - subtract constant from destination, update Z C N V H, one clock.
// - destination minus source minus carry, update Z C N V H, one clock.
// - destination minus constant minus carry, update Z C N V H, one clock.
// - subtract constant from 16-bit pair, update Z C N V S, two clocks.
// - AND with register or constant, update only Z N V, one clock.
// - OR with register or constant, update only Z N V, one clock.
// - XOR registers into destination, update Z N V, one clock.
// - complement as all-ones minus value, update Z C N V, one clock.
// - OR constant mask into destination, update Z N V, one clock.
// - AND with all-ones minus mask, update Z N V, one clock.
// - increment or decrement by one, Z N V only, carry kept, one clock.
// - test ANDs register with itself, value kept, Z N V set, one clock.
// - clear is XOR with itself giving zero, Z N V updated, one clock.
// - integer multiplies put 16-bit product in result pair, Z C, two clocks.
// - fractional multiplies shift product left one, Z C, two clocks.
module balu_core
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // operation request from the decoder
    input balu_pkg::balu_req_type req,
    output logic req_ready,
    output logic done,
    output logic [1:0] done_cycles,
    // register access port
    input balu_pkg::balu_bus_type bus,
    output logic [7:0] bus_rdata,
    // status flags
    output logic [7:0] flags
);
    import balu_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [BALU_REG_COUNT-1:0][7:0] regs;
        logic [7:0] flags;
        logic busy;
        logic [4:0] pend_idx;
        logic [15:0] pend_val;
        logic [7:0] pend_flags;
        logic done;
        logic [1:0] cycles;
        logic [7:0] rdata;
    } balu_state_type;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic h;
        logic v;
    } balu_arith_type;

    balu_state_type s_r;
    balu_state_type s_nxt;

    // ==========================================================
    // helpers
    function automatic balu_arith_type arith8(input logic [7:0] a,
        input logic [7:0] b, input logic cin, input logic sub);
        balu_arith_type o;
        logic [8:0] w;
        if (sub)
        begin
            w = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            o.res = w[7:0];
            o.c = (~a[7] & b[7]) | (b[7] & o.res[7]) | (o.res[7] & ~a[7]);
            o.h = (~a[3] & b[3]) | (b[3] & o.res[3]) | (o.res[3] & ~a[3]);
            o.v = (a[7] & ~b[7] & ~o.res[7]) | (~a[7] & b[7] & o.res[7]);
        end
        else
        begin
            w = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            o.res = w[7:0];
            o.c = w[8];
            o.h = (a[3] & b[3]) | (b[3] & ~o.res[3]) | (~o.res[3] & a[3]);
            o.v = (a[7] & b[7] & ~o.res[7]) | (~a[7] & ~b[7] & o.res[7]);
        end
        return o;
    endfunction

    // logic result flags: V cleared, N from bit 7, Z on zero
    function automatic logic [7:0] logic_flags(input logic [7:0] f,
        input logic [7:0] r);
        logic [7:0] o;
        o = f;
        o[BALU_FLAG_V] = 1'b0;
        o[BALU_FLAG_N] = r[7];
        o[BALU_FLAG_Z] = (r == 8'h00);
        return o;
    endfunction

    // ==========================================================
    // next state
    always_comb
    begin
        balu_arith_type ar;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] r;
        logic [7:0] f;
        logic [15:0] wa;
        logic [15:0] wr;
        logic [16:0] wk;
        logic [15:0] prod;
        logic [15:0] mres;
        logic signed [17:0] sprod;
        logic [4:0] lo;
        logic wb;
        ar = '0;
        r = 8'h00;
        wr = 16'h0000;
        wk = 17'h0_0000;
        prod = 16'h0000;
        mres = 16'h0000;
        sprod = '0;
        wb = 1'b0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.rdata = 8'h00;
        a = s_r.regs[req.dst];
        b = s_r.regs[req.src];
        f = s_r.flags;
        lo = {req.dst[4:1], 1'b0};
        wa = {s_r.regs[lo + 5'h01], s_r.regs[lo]};

        // bus read shows state before this edge
        if (bus.rd && bus.addr < BALU_ADDR_FLAGS)
        begin
            s_nxt.rdata = s_r.regs[bus.addr[4:0]];
        end
        else if (bus.rd && bus.addr == BALU_ADDR_FLAGS)
        begin
            s_nxt.rdata = s_r.flags;
        end
        if (bus.wr && bus.addr < BALU_ADDR_FLAGS)
        begin
            s_nxt.regs[bus.addr[4:0]] = bus.wdata;
        end
        else if (bus.wr && bus.addr == BALU_ADDR_FLAGS)
        begin
            s_nxt.flags = bus.wdata;
        end

        if (s_r.busy)
        begin
            // second clock of word and multiply operations
            s_nxt.regs[s_r.pend_idx] = s_r.pend_val[7:0];
            s_nxt.regs[s_r.pend_idx + 5'h01] = s_r.pend_val[15:8];
            s_nxt.flags = s_r.pend_flags;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.cycles = BALU_CYC_DOUBLE;
        end
        else if (req.valid)
        begin
            s_nxt.done = 1'b1;
            s_nxt.cycles = BALU_CYC_SINGLE;
            wb = 1'b1;
            case (req.op)
                OP_ADD_REGISTERS, OP_ADD_WITH_CARRY:
                begin
                    ar = arith8(a, b, (req.op == OP_ADD_WITH_CARRY) &
                        f[BALU_FLAG_C], 1'b0);
                end
                OP_SUBTRACT_REGISTERS, OP_SUBTRACT_WITH_CARRY:
                begin
                    ar = arith8(a, b, (req.op == OP_SUBTRACT_WITH_CARRY) &
                        f[BALU_FLAG_C], 1'b1);
                end
                OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_CARRY_IMMEDIATE:
                begin
                    ar = arith8(a, req.imm,
                        (req.op == OP_SUBTRACT_WITH_CARRY_IMMEDIATE) &
                        f[BALU_FLAG_C], 1'b1);
                end
                OP_AND_REGISTERS: r = a & b;
                OP_AND_IMMEDIATE: r = a & req.imm;
                OP_OR_REGISTERS: r = a | b;
                OP_OR_IMMEDIATE: r = a | req.imm;
                OP_XOR_REGISTERS: r = a ^ b;
                OP_ONES_COMPLEMENT: r = BALU_ALL_ONES - a;
                OP_BIT_SET: r = a | req.imm;
                OP_BIT_CLEAR: r = a & (BALU_ALL_ONES - req.imm);
                OP_INCREMENT: r = a + 8'h01;
                OP_DECREMENT: r = a - 8'h01;
                OP_TEST: r = a & a;
                OP_CLEAR: r = a ^ a;
                OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE:
                begin
                    wb = 1'b0;
                    s_nxt.done = 1'b0;
                    s_nxt.busy = 1'b1;
                    s_nxt.pend_idx = lo;
                    if (req.op == OP_WORD_ADD_IMMEDIATE)
                    begin
                        wk = {1'b0, wa} + {11'h000, req.imm[5:0]};
                    end
                    else
                    begin
                        wk = {1'b0, wa} - {11'h000, req.imm[5:0]};
                    end
                    wr = wk[15:0];
                    s_nxt.pend_val = wr;
                    s_nxt.pend_flags = f;
                    s_nxt.pend_flags[BALU_FLAG_Z] = (wr == 16'h0000);
                    s_nxt.pend_flags[BALU_FLAG_N] = wr[15];
                    if (req.op == OP_WORD_ADD_IMMEDIATE)
                    begin
                        s_nxt.pend_flags[BALU_FLAG_V] = ~wa[15] & wr[15];
                        s_nxt.pend_flags[BALU_FLAG_C] = wa[15] & ~wr[15];
                    end
                    else
                    begin
                        s_nxt.pend_flags[BALU_FLAG_V] = wa[15] & ~wr[15];
                        s_nxt.pend_flags[BALU_FLAG_C] = ~wa[15] & wr[15];
                    end
                    s_nxt.pend_flags[BALU_FLAG_S] = wr[15] ^
                        s_nxt.pend_flags[BALU_FLAG_V];
                end
                OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED,
                OP_MULTIPLY_SIGNED_UNSIGNED, OP_FRAC_MULTIPLY_UNSIGNED,
                OP_FRAC_MULTIPLY_SIGNED, OP_FRAC_MULTIPLY_SIGNED_UNSIGNED:
                begin
                    wb = 1'b0;
                    s_nxt.done = 1'b0;
                    s_nxt.busy = 1'b1;
                    s_nxt.pend_idx = BALU_PROD_LOW_IDX;
                    // sign-extend per variant, keep the low 16 bits
                    case (req.op)
                        OP_MULTIPLY_SIGNED, OP_FRAC_MULTIPLY_SIGNED:
                        begin
                            sprod = $signed({{1{a[7]}}, a[7], a}) *
                                $signed({{1{b[7]}}, b[7], b});
                        end
                        OP_MULTIPLY_SIGNED_UNSIGNED,
                        OP_FRAC_MULTIPLY_SIGNED_UNSIGNED:
                        begin
                            sprod = $signed({a[7], a[7], a}) *
                                $signed({2'b00, b});
                        end
                        default:
                        begin
                            sprod = $signed({2'b00, a}) *
                                $signed({2'b00, b});
                        end
                    endcase
                    prod = sprod[15:0];
                    if (req.op == OP_FRAC_MULTIPLY_UNSIGNED ||
                        req.op == OP_FRAC_MULTIPLY_SIGNED ||
                        req.op == OP_FRAC_MULTIPLY_SIGNED_UNSIGNED)
                    begin
                        mres = {prod[14:0], 1'b0};
                    end
                    else
                    begin
                        mres = prod;
                    end
                    s_nxt.pend_val = mres;
                    s_nxt.pend_flags = f;
                    // carry is bit 15 of the product before any shift
                    s_nxt.pend_flags[BALU_FLAG_C] = prod[15];
                    s_nxt.pend_flags[BALU_FLAG_Z] = (mres == 16'h0000);
                end
                default:
                begin
                    wb = 1'b0;
                end
            endcase

            // flag update per operation group, others kept
            case (req.op)
                OP_ADD_REGISTERS, OP_ADD_WITH_CARRY,
                OP_SUBTRACT_REGISTERS, OP_SUBTRACT_IMMEDIATE,
                OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_WITH_CARRY_IMMEDIATE:
                begin
                    r = ar.res;
                    s_nxt.flags[BALU_FLAG_C] = ar.c;
                    s_nxt.flags[BALU_FLAG_H] = ar.h;
                    s_nxt.flags[BALU_FLAG_V] = ar.v;
                    s_nxt.flags[BALU_FLAG_N] = r[7];
                    // borrow chains keep Z sticky across bytes
                    if (req.op == OP_SUBTRACT_WITH_CARRY ||
                        req.op == OP_SUBTRACT_WITH_CARRY_IMMEDIATE)
                    begin
                        s_nxt.flags[BALU_FLAG_Z] = (r == 8'h00) &
                            f[BALU_FLAG_Z];
                    end
                    else
                    begin
                        s_nxt.flags[BALU_FLAG_Z] = (r == 8'h00);
                    end
                end
                OP_ONES_COMPLEMENT:
                begin
                    s_nxt.flags = logic_flags(f, r);
                    s_nxt.flags[BALU_FLAG_C] = 1'b1;
                end
                OP_INCREMENT:
                begin
                    s_nxt.flags = logic_flags(f, r);
                    s_nxt.flags[BALU_FLAG_V] = (r == 8'h80);
                end
                OP_DECREMENT:
                begin
                    s_nxt.flags = logic_flags(f, r);
                    s_nxt.flags[BALU_FLAG_V] = (r == 8'h7f);
                end
                OP_AND_REGISTERS, OP_AND_IMMEDIATE, OP_OR_REGISTERS,
                OP_OR_IMMEDIATE, OP_XOR_REGISTERS, OP_BIT_SET,
                OP_BIT_CLEAR, OP_TEST, OP_CLEAR:
                begin
                    s_nxt.flags = logic_flags(f, r);
                end
                default:
                begin
                    s_nxt.flags = s_nxt.flags;
                end
            endcase
            if (wb)
            begin
                s_nxt.regs[req.dst] = r;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '0;
            s_r.regs <= {BALU_REG_COUNT{BALU_GPR_RST}};
            s_r.flags <= BALU_FLAGS_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign req_ready = ~s_r.busy;
    assign done = s_r.done;
    assign done_cycles = s_r.cycles;
    assign bus_rdata = s_r.rdata;
    assign flags = s_r.flags;

endmodule

// >>> sim/balu_far_end.sv
// decoder and register-loading model driving the datapath's request and bus
`timescale 1ns/100ps
module balu_far_end
(
    // clock
    input wire logic sys_clk,
    // requests toward the datapath
    output balu_pkg::balu_req_type req,
    output balu_pkg::balu_bus_type bus,
    // answers from the datapath
    input wire logic req_ready,
    input wire logic [7:0] bus_rdata
);
    import balu_pkg::*;

    initial
    begin
        req = '0;
        bus = '0;
    end

    // ==========================================================
    // operation requests
    // ready sampled mid-cycle; a valid held while busy is ignored
    task automatic issue(balu_op_type op, logic [4:0] d, s, logic [7:0] k);
        req <= '{1'b1, op, d, s, k};
        @(negedge sys_clk);
        while (req_ready !== 1'b1)
            @(negedge sys_clk);
        @(posedge sys_clk);
    endtask

    task automatic idle();
        req.valid <= 1'b0;
    endtask

    // ==========================================================
    // register bus
    // released lines carry junk so stale values cannot pass
    task automatic poke(input logic [5:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        bus <= '{~a, ~d, 1'b0, 1'b0};
        @(posedge sys_clk);
    endtask

    task automatic peek(input logic [5:0] a, output logic [7:0] d);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        bus <= '{~a, 8'h5a, 1'b0, 1'b0};
        @(negedge sys_clk);
        d = bus_rdata;
        @(posedge sys_clk);
    endtask
endmodule

// >>> sim/balu_core_props.sv
// timing and flag-preservation checks on the datapath ports
`timescale 1ns/100ps
module balu_core_props
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // operation port
    input balu_pkg::balu_req_type req,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [1:0] done_cycles,
    // register port
    input balu_pkg::balu_bus_type bus,
    input wire logic [7:0] bus_rdata,
    // flags
    input wire logic [7:0] flags
);
    import balu_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    logic take, take_one, take_mul, take_word, take_logic, take_inv;
    assign take = req.valid && req_ready;
    assign take_mul = take && req.op inside
        {[OP_MULTIPLY_UNSIGNED:OP_FRAC_MULTIPLY_SIGNED_UNSIGNED]};
    assign take_word = take && req.op inside
        {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE};
    assign take_one = take && req.op <= OP_CLEAR && !take_word;
    assign take_inv = take && req.op == OP_ONES_COMPLEMENT;
    // complement sets carry, so it is left out
    assign take_logic = take && !take_inv
        && req.op inside {[OP_AND_REGISTERS:OP_CLEAR]};

    // ==========================================================
    // assertions
    one_clock_done_a: assert property (take_one |=> done
        && done_cycles == BALU_CYC_SINGLE) else $error("one-clock op late");
    two_clock_done_a: assert property ((take_mul || take_word)
        |=> !req_ready && !done ##1 done && done_cycles == BALU_CYC_DOUBLE)
        else $error("two-clock op timing wrong");
    word_flags_kept_a: assert property (take_word
        |=> ##1 flags[7:5] == $past(flags[7:5], 2))
        else $error("word op touched H T or I");
    mul_flags_kept_a: assert property (take_mul
        |=> ##1 flags[7:2] == $past(flags[7:2], 2))
        else $error("multiply touched flags beyond Z C");
    logic_flags_kept_a: assert property (take_logic
        |=> (flags & 8'hf1) == ($past(flags) & 8'hf1))
        else $error("logic op touched C S H T or I");
    invert_carry_set_a: assert property (take_inv
        |=> flags[0] && !flags[3] && flags[7:4] == $past(flags[7:4]))
        else $error("complement flags wrong");
    clear_flags_a: assert property (take && req.op == OP_CLEAR
        |=> flags[1] && !flags[2] && !flags[3])
        else $error("clear flags wrong");
    busy_one_cycle_a: assert property (!req_ready |=> req_ready)
        else $error("busy longer than one cycle");
    read_idle_zero_a: assert property (!bus.rd |=> bus_rdata == 8'h00)
        else $error("read data outside read answer");
endmodule

bind balu_core balu_core_props props_u
(
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .req(req),
    .req_ready(req_ready),
    .done(done),
    .done_cycles(done_cycles),
    .bus(bus),
    .bus_rdata(bus_rdata),
    .flags(flags)
);

// >>> sim/balu_core_test.sv
// self-checking bench for the byte datapath
`timescale 1ns/100ps
module balu_core_test;
    import balu_pkg::*;

    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    balu_req_type req;
    balu_bus_type bus;
    logic req_ready, done;
    logic [1:0] done_cycles;
    logic [7:0] bus_rdata, flags, flag_m;
    int num_errors = 0;
    int compares = 0;

    always #5 sys_clk = ~sys_clk;

    balu_core dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
        .req_ready(req_ready), .done(done), .done_cycles(done_cycles),
        .bus(bus), .bus_rdata(bus_rdata), .flags(flags));
    balu_far_end far_u (.sys_clk(sys_clk), .req(req), .bus(bus),
        .req_ready(req_ready), .bus_rdata(bus_rdata));

    // ==========================================================
    // shared helpers
    task automatic check(string what, logic [15:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic expect_byte(string what, logic [5:0] a, logic [7:0] e);
        logic [7:0] v;
        far_u.peek(a, v);
        check(what, v, e);
    endtask

    // bounded wait so a lost done cannot hang the run
    task automatic run_op(balu_op_type op, logic [4:0] d, s, logic [7:0] k,
        logic [1:0] cyc = BALU_CYC_SINGLE);
        int n;
        far_u.issue(op, d, s, k);
        far_u.idle();
        n = 0;
        @(negedge sys_clk);
        while (done !== 1'b1 && n < 4)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("done and cost", {done, done_cycles}, {1'b1, cyc});
        @(posedge sys_clk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        expect_byte("flags", BALU_ADDR_FLAGS, BALU_FLAGS_RST);
        expect_byte("r31", 6'h1f, BALU_GPR_RST);
        far_u.poke(6'h21, 8'h55);
        expect_byte("unmapped", 6'h21, 8'h00);
        $display("test reset finished");
    endtask

    task automatic t_arith();
        far_u.poke(BALU_ADDR_FLAGS, 8'hc0);
        far_u.poke(6'h02, 8'h8f);
        far_u.poke(6'h03, 8'h71);
        run_op(OP_ADD_REGISTERS, 5'h02, 5'h03, 8'h00);
        expect_byte("add", 6'h02, 8'h00);
        expect_byte("add flags", BALU_ADDR_FLAGS, 8'he3);
        far_u.poke(6'h04, 8'h7f);
        run_op(OP_ADD_WITH_CARRY, 5'h04, 5'h05, 8'h00);
        expect_byte("adc", 6'h04, 8'h80);
        expect_byte("adc flags", BALU_ADDR_FLAGS, 8'hec);
        far_u.poke(6'h06, 8'h10);
        far_u.poke(6'h07, 8'h20);
        run_op(OP_SUBTRACT_REGISTERS, 5'h06, 5'h07, 8'h00);
        expect_byte("sub", 6'h06, 8'hf0);
        expect_byte("sub flags", BALU_ADDR_FLAGS, 8'hc5);
        run_op(OP_SUBTRACT_WITH_CARRY, 5'h06, 5'h07, 8'h00);
        expect_byte("sbr", 6'h06, 8'hcf);
        expect_byte("sbr flags", BALU_ADDR_FLAGS, 8'he4);
        far_u.poke(6'h08, 8'h05);
        run_op(OP_SUBTRACT_IMMEDIATE, 5'h08, 5'h00, 8'h05);
        expect_byte("subtract_immediate flags", BALU_ADDR_FLAGS, 8'hc2);
        run_op(OP_SUBTRACT_WITH_CARRY_IMMEDIATE, 5'h08, 5'h00, 8'hff);
        expect_byte("sbri", 6'h08, 8'h01);
        expect_byte("sbri flags", BALU_ADDR_FLAGS, 8'he1);
        // odd index and high constant bits must both be dropped
        far_u.poke(6'h18, 8'hff);
        far_u.poke(6'h19, 8'h7f);
        run_op(OP_WORD_ADD_IMMEDIATE, 5'h19, 5'h00, 8'hc1, BALU_CYC_DOUBLE);
        expect_byte("word add low", 6'h18, 8'h00);
        expect_byte("word add high", 6'h19, 8'h80);
        expect_byte("word add flags", BALU_ADDR_FLAGS, 8'hec);
        run_op(OP_WORD_SUBTRACT_IMMEDIATE, 5'h18, 5'h00, 8'h01,
               BALU_CYC_DOUBLE);
        expect_byte("word sub low", 6'h18, 8'hff);
        expect_byte("word sub flags", BALU_ADDR_FLAGS, 8'hf8);
        flag_m = 8'hf8;
        $display("test arithmetic finished");
    endtask

    task automatic t_logic();
        balu_op_type ops [12] = '{OP_AND_REGISTERS, OP_AND_IMMEDIATE,
            OP_OR_REGISTERS, OP_OR_IMMEDIATE, OP_XOR_REGISTERS, OP_BIT_SET,
            OP_BIT_CLEAR, OP_ONES_COMPLEMENT, OP_INCREMENT, OP_DECREMENT,
            OP_TEST, OP_CLEAR};
        logic [7:0] a, r;
        foreach (ops[i])
            for (int j = 0; j < 2; j++)
            begin
                a = (j == 1) ? 8'h80 : 8'h7f;
                far_u.poke(6'h0c, a);
                far_u.poke(6'h0d, 8'h3c);
                run_op(ops[i], 5'h0c, 5'h0d, 8'h3c);
                case (ops[i])
                    OP_AND_REGISTERS, OP_AND_IMMEDIATE: r = a & 8'h3c;
                    OP_XOR_REGISTERS: r = a ^ 8'h3c;
                    OP_ONES_COMPLEMENT: r = BALU_ALL_ONES - a;
                    OP_BIT_CLEAR: r = a & (BALU_ALL_ONES - 8'h3c);
                    OP_INCREMENT: r = a + 8'h01;
                    OP_DECREMENT: r = a - 8'h01;
                    OP_TEST: r = a;
                    OP_CLEAR: r = 8'h00;
                    default: r = a | 8'h3c;
                endcase
                expect_byte(ops[i].name(), 6'h0c, r);
                flag_m[BALU_FLAG_Z] = (r == 8'h00);
                flag_m[BALU_FLAG_N] = r[7];
                flag_m[BALU_FLAG_V] = (ops[i] == OP_INCREMENT && r == 8'h80)
                    || (ops[i] == OP_DECREMENT && r == 8'h7f);
                if (ops[i] == OP_ONES_COMPLEMENT)
                    flag_m[BALU_FLAG_C] = 1'b1;
                expect_byte("logic flags", BALU_ADDR_FLAGS, flag_m);
            end
        $display("test logic finished");
    endtask

    task automatic t_product();
        balu_op_type ops [6] = '{OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED,
            OP_MULTIPLY_SIGNED_UNSIGNED, OP_FRAC_MULTIPLY_UNSIGNED,
            OP_FRAC_MULTIPLY_SIGNED, OP_FRAC_MULTIPLY_SIGNED_UNSIGNED};
        logic signed [16:0] x, y;
        logic [15:0] p;
        far_u.poke(6'h10, 8'hc0);
        far_u.poke(6'h11, 8'hc0);
        foreach (ops[i])
        begin
            // destination signed for all but the unsigned forms
            x = $signed({{9{(i % 3 != 0)}}, 8'hc0});
            y = $signed({{9{(i % 3 == 1)}}, 8'hc0});
            p = 16'(x * y);
            flag_m[BALU_FLAG_C] = p[15];
            if (i >= 3)
                p = p << 1;
            flag_m[BALU_FLAG_Z] = (p == 16'h0000);
            run_op(ops[i], 5'h10, 5'h11, 8'h00, BALU_CYC_DOUBLE);
            expect_byte("product low", 6'h00, p[7:0]);
            expect_byte("product high", 6'h01, p[15:8]);
            expect_byte("product flags", BALU_ADDR_FLAGS, flag_m);
        end
        $display("test product finished");
    endtask

    // a request held through the busy cycle must count once only
    task automatic t_order();
        far_u.poke(6'h14, 8'h00);
        far_u.issue(OP_INCREMENT, 5'h14, 5'h00, 8'h00);
        far_u.issue(OP_INCREMENT, 5'h14, 5'h00, 8'h00);
        far_u.issue(OP_WORD_ADD_IMMEDIATE, 5'h1a, 5'h00, 8'h01);
        far_u.issue(OP_INCREMENT, 5'h14, 5'h00, 8'h00);
        far_u.idle();
        repeat (2) @(posedge sys_clk);
        expect_byte("back to back", 6'h14, 8'h03);
        expect_byte("word pair", 6'h1a, 8'h01);
        $display("test order finished");
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_arith();
        t_logic();
        t_product();
        t_order();
        stop_test();
    end

    // the whole run needs about 400 cycles
    initial
    begin
        #50000;
        num_errors++;
        stop_test();
    end
endmodule
